//--- design/compare_a_value_pkg.sv
// Package: register map, field layout and encodings for compare channel A
package compare_a_value_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] OFS_VALUE   = 12'h000;
    localparam logic [11:0] OFS_CONTROL = 12'h004;
    localparam logic [11:0] OFS_ACTION  = 12'h008;
    localparam logic [11:0] OFS_STATUS  = 12'h00c;
    // Control register fields
    localparam int CTL_DIRECT_BIT = 4;
    localparam int CTL_LOAD_LSB   = 0;
    localparam int CTL_LOAD_W     = 2;
    localparam int CTL_FULL_BIT   = 8;
    // Action configuration fields (output a low, output b high)
    localparam int ACT_A_LSB = 0;
    localparam int ACT_B_LSB = 2;
    localparam int ACT_W     = 2;
    // Number of PWM outputs driven by the action qualifier
    localparam int OUT_N     = 2;
    // Status register fields
    localparam int STS_OUT_A_BIT = 0;
    localparam int STS_OUT_B_BIT = 1;
    localparam int STS_FULL_BIT  = 2;
    // Reset values
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic        DIRECT_RST = 1'b0;
    localparam logic [1:0]  LOAD_RST   = 2'h0;

    // Action on a compare event
    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_CLEAR  = 2'h1,
        ACT_SET    = 2'h2,
        ACT_TOGGLE = 2'h3
    } action_t;

    // Load-select codes: which time-base event moves the shadow
    typedef enum logic [1:0] {
        LOAD_ZERO   = 2'h0,
        LOAD_PERIOD = 2'h1,
        LOAD_EITHER = 2'h2,
        LOAD_FREEZE = 2'h3
    } load_sel_t;

    // Time-base event bundle
    typedef struct packed {
        logic       update;
        logic       at_zero;
        logic       at_period;
        logic [15:0] count;
    } timebase_t;
endpackage : compare_a_value_pkg

//--- design/pwm_compare_a_shadowed.sv
// Compare channel A with shadow register, APB slave and output actions
// Functional notes
// [R1] Active 16-bit value compared on each count update
// [R2] Count equal to active value raises event
// [R3] Event forwarded to action logic for both outputs
// [R4] Per output: ignore, clear, set or toggle
// [R5] Reset leaves the channel in shadowed mode
// [R6] Direct bit zero: accesses reach shadow copy
// [R7] Shadow loads active only on selected event
// [R8] Readable pending flag shows shadow still full
// [R9] Direct bit one: accesses hit active value
// [R10] Both copies share one address
// [R11] Write sets pending flag, load clears it
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module pwm_compare_a_shadowed
    import compare_a_value_pkg::*;
#(
    parameter int CMP_W = 16
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Time-base counter
    input  wire timebase_t   timebase,
    // Compare event and PWM outputs
    output logic             compare_a_event,
    output logic             pwm_out_a,
    output logic             pwm_out_b
);

    // Register state
    logic [CMP_W-1:0] active_r;
    logic [CMP_W-1:0] shadow_r;
    logic             compare_a_direct_access_r;
    load_sel_t        compare_a_load_select_r;
    logic             compare_a_pending_flag_r;
    action_t          action_config_a_r;
    action_t          action_config_b_r;
    logic             event_r;
    logic             out_a_r;
    logic             out_b_r;
    logic             pready_r;
    logic [31:0]      prdata_r;
    logic             pslverr_r;

    // Decoded bus strobes
    logic             setup;
    logic             wr_value;
    logic             wr_control;
    logic             wr_action;
    logic             load_hit;
    logic             match;
    logic [31:0]      rd_nxt;
    logic             mapped;
    logic             access;
    logic             shadowed;
    logic [31:0]      value_word;
    logic [31:0]      control_word;
    logic [31:0]      action_word;
    logic [31:0]      status_word;

    // Next values of the register state
    logic             pready_nxt;
    logic             pslverr_nxt;
    logic [31:0]      prdata_nxt;
    logic             compare_a_direct_access_nxt;
    load_sel_t        compare_a_load_select_nxt;
    action_t          action_config_a_nxt;
    action_t          action_config_b_nxt;
    logic [CMP_W-1:0] shadow_nxt;
    logic [CMP_W-1:0] active_nxt;
    logic             pending_nxt;

    // Applies one action to an output level
    function automatic logic apply_action(input action_t act,
                                          input logic cur);
        logic res;
        res = cur;
        unique case (act)
            ACT_NONE:   res = cur;
            ACT_CLEAR:  res = 1'b0;
            ACT_SET:    res = 1'b1;
            ACT_TOGGLE: res = ~cur;
        endcase
        return res;
    endfunction : apply_action

    // Checks whether an address selects the given register offset
    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [11:0] ofs);
        return a == ofs;
    endfunction : is_reg

    // Setup latches read data; the ready access cycle commits writes
    assign setup      = psel & ~penable;
    assign access     = psel & penable & pready_r;
    assign wr_value   = access & pwrite & is_reg(paddr, OFS_VALUE); // [R10]
    assign wr_control = access & pwrite & is_reg(paddr, OFS_CONTROL);
    assign wr_action  = access & pwrite & is_reg(paddr, OFS_ACTION);

    // Shadowed mode while the direct bit is clear
    assign shadowed   = ~compare_a_direct_access_r; // [R6] [R9]
    assign mapped     = is_reg(paddr, OFS_VALUE)
                      | is_reg(paddr, OFS_CONTROL)
                      | is_reg(paddr, OFS_ACTION)
                      | is_reg(paddr, OFS_STATUS);

    // Selected time-base event for the shadow transfer
    always_comb begin
        unique case (compare_a_load_select_r)
            LOAD_ZERO:   load_hit = timebase.at_zero;
            LOAD_PERIOD: load_hit = timebase.at_period;
            LOAD_EITHER: load_hit = timebase.at_zero | timebase.at_period;
            LOAD_FREEZE: load_hit = 1'b0;
        endcase
        load_hit = load_hit & timebase.update;
    end

    // Equality of count and active value on a count update
    assign match = timebase.update
                 & (timebase.count == active_r); // [R1] [R2]

    // Read view of the value address, copy chosen by the direct bit
    always_comb begin
        value_word = 32'h0000_0000;
        value_word[CMP_W-1:0] = shadowed ? shadow_r
                                         : active_r; // [R6] [R9] [R10]
    end

    // Read view of the control word, pending flag read-only
    always_comb begin
        control_word = 32'h0000_0000;
        control_word[CTL_LOAD_LSB +: CTL_LOAD_W] = compare_a_load_select_r;
        control_word[CTL_DIRECT_BIT] = compare_a_direct_access_r;
        control_word[CTL_FULL_BIT]   = compare_a_pending_flag_r; // [R8]
    end

    // Read view of the action word
    always_comb begin
        action_word = 32'h0000_0000;
        action_word[ACT_A_LSB +: ACT_W] = action_config_a_r;
        action_word[ACT_B_LSB +: ACT_W] = action_config_b_r;
    end

    // Read view of the status word
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STS_OUT_A_BIT] = out_a_r;
        status_word[STS_OUT_B_BIT] = out_b_r;
        status_word[STS_FULL_BIT]  = compare_a_pending_flag_r; // [R8]
    end

    // Read data mux; unmapped offsets read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (is_reg(paddr, OFS_VALUE)) begin
            rd_nxt = value_word; // [R10]
        end else if (is_reg(paddr, OFS_CONTROL)) begin
            rd_nxt = control_word;
        end else if (is_reg(paddr, OFS_ACTION)) begin
            rd_nxt = action_word;
        end else if (is_reg(paddr, OFS_STATUS)) begin
            rd_nxt = status_word;
        end
    end

    // APB answer: next values, ready one cycle after setup
    always_comb begin
        pready_nxt  = setup;
        pslverr_nxt = setup & ~mapped;
        prdata_nxt  = prdata_r;
        if (setup && !pwrite) begin
            prdata_nxt = rd_nxt;
        end
    end

    // APB answer state; read data holds until the next read
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Control register: next value on an accepted write
    always_comb begin
        compare_a_direct_access_nxt = compare_a_direct_access_r;
        compare_a_load_select_nxt   = compare_a_load_select_r;
        if (wr_control) begin
            compare_a_direct_access_nxt = pwdata[CTL_DIRECT_BIT];
            compare_a_load_select_nxt   =
                load_sel_t'(pwdata[CTL_LOAD_LSB +: CTL_LOAD_W]);
        end
    end

    // Control register state
    always_ff @(posedge clk) begin
        if (srst) begin
            compare_a_direct_access_r <= DIRECT_RST; // [R5]
            compare_a_load_select_r   <= load_sel_t'(LOAD_RST);
        end else if (ce) begin
            compare_a_direct_access_r <= compare_a_direct_access_nxt;
            compare_a_load_select_r   <= compare_a_load_select_nxt;
        end
    end

    // Action configuration: next value on an accepted write
    always_comb begin
        action_config_a_nxt = action_config_a_r;
        action_config_b_nxt = action_config_b_r;
        if (wr_action) begin
            action_config_a_nxt = action_t'(pwdata[ACT_A_LSB +: ACT_W]);
            action_config_b_nxt = action_t'(pwdata[ACT_B_LSB +: ACT_W]);
        end
    end

    // Action configuration state
    always_ff @(posedge clk) begin
        if (srst) begin
            action_config_a_r <= ACT_NONE;
            action_config_b_r <= ACT_NONE;
        end else if (ce) begin
            action_config_a_r <= action_config_a_nxt;
            action_config_b_r <= action_config_b_nxt;
        end
    end

    // Shadow copy: takes writes only in shadowed mode
    always_comb begin
        shadow_nxt = shadow_r;
        if (wr_value && shadowed) begin
            shadow_nxt = pwdata[CMP_W-1:0]; // [R6]
        end
    end

    // Shadow copy state
    always_ff @(posedge clk) begin
        if (srst) begin
            shadow_r <= VALUE_RST;
        end else if (ce) begin
            shadow_r <= shadow_nxt;
        end
    end

    // Active copy: direct write, or shadow load on selected event
    always_comb begin
        active_nxt = active_r;
        if (wr_value && !shadowed) begin
            active_nxt = pwdata[CMP_W-1:0]; // [R9]
        end else if (shadowed && load_hit) begin
            active_nxt = shadow_r; // [R7]
        end
    end

    // Active copy state; a same-cycle write loads the old shadow
    always_ff @(posedge clk) begin
        if (srst) begin
            active_r <= VALUE_RST;
        end else if (ce) begin
            active_r <= active_nxt; // [R1]
        end
    end

    // Pending flag: a new write wins over a same-cycle load
    always_comb begin
        pending_nxt = compare_a_pending_flag_r;
        if (wr_value && shadowed) begin
            pending_nxt = 1'b1; // [R11] [R8]
        end else if (shadowed && load_hit) begin
            pending_nxt = 1'b0; // [R11]
        end
    end

    // Pending flag state
    always_ff @(posedge clk) begin
        if (srst) begin
            compare_a_pending_flag_r <= 1'b0;
        end else if (ce) begin
            compare_a_pending_flag_r <= pending_nxt;
        end
    end

    // Compare event: one-cycle pulse after a match
    always_ff @(posedge clk) begin
        if (srst) begin
            event_r <= 1'b0;
        end else if (ce) begin
            event_r <= match; // [R2] [R3]
        end
    end

    // Action qualifier, one copy for each output
    for (genvar i = 0; i < OUT_N; i++) begin : g_out
        action_t cfg;
        logic    level_r;
        logic    level_nxt;
        // Configuration of this output
        assign cfg = (i == 0) ? action_config_a_r : action_config_b_r;
        // Level after the event, held otherwise
        always_comb begin
            level_nxt = level_r;
            if (match) begin
                level_nxt = apply_action(cfg, level_r); // [R4]
            end
        end
        // Output level state
        always_ff @(posedge clk) begin
            if (srst) begin
                level_r <= 1'b0;
            end else if (ce) begin
                level_r <= level_nxt; // [R3]
            end
        end
    end

    // Output levels picked from the per-output copies
    assign out_a_r = g_out[0].level_r;
    assign out_b_r = g_out[1].level_r;

    // Outputs straight from flip-flops
    assign pready          = pready_r;
    assign prdata          = prdata_r;
    assign pslverr         = pslverr_r;
    assign compare_a_event = event_r;
    assign pwm_out_a       = out_a_r;
    assign pwm_out_b       = out_b_r;

endmodule : pwm_compare_a_shadowed
`default_nettype wire

//--- bench/compare_a_value_checker_assertions.sv
// Port checker for compare channel A
`timescale 1ns/10ps
`default_nettype none
module compare_a_value_checker
    import compare_a_value_pkg::*;
(
    // Clock and reset
    input wire logic      clk,
    input wire logic      srst,
    input wire logic      ce,
    // APB handshake
    input wire logic      psel,
    input wire logic      penable,
    input wire logic      pready,
    input wire logic      pslverr,
    // Time base and outputs
    input wire timebase_t timebase,
    input wire logic      compare_a_event,
    input wire logic      pwm_out_a,
    input wire logic      pwm_out_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Bus answer timing
    ack_setup_a: assert property (psel && !penable && ce |=> pready)
        else $error("no ready after setup");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    rdy_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    err_with_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Event and outputs
    ev_cause_a: assert property (compare_a_event |-> $past(timebase.update))
        else $error("event without count update");
    ev_idle_a: assert property (ce && !timebase.update |=> !compare_a_event)
        else $error("event while count idle");
    out_hold_a: assert property (!compare_a_event |->
        $stable({pwm_out_a, pwm_out_b}))
        else $error("output moved without event");
    rst_quiet_a: assert property ($fell(srst) |->
        !pwm_out_a && !pwm_out_b && !compare_a_event)
        else $error("outputs not cleared by reset");
endmodule : compare_a_value_checker

bind pwm_compare_a_shadowed compare_a_value_checker compare_a_value_checker_i (
    .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .timebase(timebase),
    .compare_a_event(compare_a_event), .pwm_out_a(pwm_out_a),
    .pwm_out_b(pwm_out_b));
`default_nettype wire

//--- bench/timebase_model.sv
// Up-counting time-base model feeding the compare channel
`timescale 1ns/10ps
`default_nettype none
module timebase_model
    import compare_a_value_pkg::*;
#(
    parameter logic [15:0] PRD = 16'h000f
) (
    // Clock and control
    input  wire logic      clk,
    input  wire logic      srst,
    input  wire logic      run,
    // Time-base bundle
    output wire timebase_t tb
);
    logic [15:0] count_r;
    // Count zero to period, one step a cycle
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            count_r <= 16'h0000;
        end else begin
            count_r <= (count_r == PRD) ? 16'h0000 : count_r + 16'h0001;
        end
    end
    // Update every cycle while running
    assign tb = '{update: run, at_zero: count_r == 16'h0000,
                  at_period: count_r == PRD, count: count_r};
endmodule : timebase_model
`default_nettype wire

//--- bench/pwm_compare_a_shadowed_bench.sv
// Bench for compare channel A: APB, shadow loads, actions
`timescale 1ns/10ps
`default_nettype none
module pwm_compare_a_shadowed_bench;
    import compare_a_value_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, run = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, ev, pa, pb, ea = 1'b0, eb = 1'b0;
    logic [15:0] prev_cnt;
    logic [1:0]  act_a = 2'h0, act_b = 2'h0;
    timebase_t   tb;
    int          fail_count = 0, comparisons = 0;

    // Clock and last sampled count
    always #4 clk = ~clk;
    always @(posedge clk) prev_cnt <= tb.count;
    timebase_model timebase_model_i (.clk(clk), .srst(srst), .run(run),
        .tb(tb));
    pwm_compare_a_shadowed pwm_compare_a_shadowed_i (.clk(clk), .srst(srst),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timebase(tb), .compare_a_event(ev),
        .pwm_out_a(pa), .pwm_out_b(pb));

    task automatic summarize;
        $display("Counts: %0d compares, %0d bad", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // One APB transfer; result in q
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        chk({31'h0, pslverr}, {31'h0, a > OFS_STATUS});
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            summarize();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic setact(input logic [1:0] a, input logic [1:0] b);
        act_a = a;
        act_b = b;
        wr(OFS_ACTION, {28'h0, b, a});
    endtask : setact
    function automatic logic nxt(input logic [1:0] c, input logic v);
        return c == 2'h1 ? 1'b0 : c == 2'h2 ? 1'b1 : c == 2'h3 ? ~v : v;
    endfunction : nxt
    // Wait for an event, then judge its count and the outputs
    task automatic ev_chk(input logic [15:0] c);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ev !== 1'b1 && n < 40);
        ea = nxt(act_a, ea);
        eb = nxt(act_b, eb);
        chk({16'h0, prev_cnt}, {16'h0, c});
        chk({30'h0, pa, pb}, {30'h0, ea, eb});
        if (n >= 40) begin
            fail_count++;
            summarize();
        end
    endtask : ev_chk

    task automatic t_reset;
        rd(OFS_VALUE, 32'h0);
        rd(OFS_CONTROL, 32'h0);
        rd(12'h010, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_shadow;
        int n;
        run <= 1'b1;
        wr(OFS_CONTROL, 32'h1);
        wr(OFS_VALUE, 32'h8);
        rd(OFS_CONTROL, 32'h101);
        rd(OFS_VALUE, 32'h8);
        n = 0;
        do begin
            apb(1'b0, OFS_CONTROL, 32'h0);
            n++;
        end while (q[CTL_FULL_BIT] !== 1'b0 && n < 20);
        chk(q, 32'h1);
        setact(2'h2, 2'h3);
        ev_chk(16'h8);
        $display("shadow test done");
    endtask : t_shadow
    // Frozen load keeps the shadow pending across events
    task automatic t_freeze;
        wr(OFS_CONTROL, 32'h3);
        wr(OFS_VALUE, 32'h7);
        ev_chk(16'h8);
        rd(OFS_CONTROL, 32'h103);
        rd(OFS_VALUE, 32'h7);
        ev_chk(16'h8);
        $display("freeze test done");
    endtask : t_freeze
    task automatic t_direct;
        wr(OFS_CONTROL, 32'h10);
        wr(OFS_VALUE, 32'h3);
        for (int a = 0; a < 4; a++) begin
            ev_chk(16'h3);
            setact(2'(a), 2'(3 - a));
        end
        ev_chk(16'h3);
        rd(OFS_VALUE, 32'h3);
        $display("direct test done");
    endtask : t_direct
    // Zero and either-edge loads move the shadow in shadowed mode
    task automatic t_loads;
        int n;
        setact(2'h2, 2'h1);
        for (int m = 0; m < 3; m += 2) begin
            wr(OFS_CONTROL, 32'(m));
            wr(OFS_VALUE, 32'(5 + m));
            n = 0;
            do begin
                apb(1'b0, OFS_CONTROL, 32'h0);
                n++;
            end while (q[CTL_FULL_BIT] !== 1'b0 && n < 20);
            chk(q, 32'(m));
            ev_chk(16'(5 + m));
        end
        $display("load test done");
    endtask : t_loads

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_shadow();
        t_freeze();
        t_direct();
        t_loads();
        summarize();
    end
endmodule : pwm_compare_a_shadowed_bench
`default_nettype wire
